// [src/pifb_pkg.sv]
// Package for the peripheral interrupt flag bank: offsets, bit positions, masks, carriers.
// Assumes an 8-bit register port addressed by 12-bit printed offsets.
package pifb_pkg;

  // Flag register count and widths
  localparam int FLAG_REGS = 5;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int EXT_COUNT = 3;
  localparam int PIN_COUNT = 8;
  localparam int SEL_W = 3;

  // Flag register offsets
  localparam logic [ADDR_W-1:0] TIMER_PIN_EVENT_FLAGS_OFS = 12'hEC5;
  localparam logic [ADDR_W-1:0] CLOCK_CONVERTER_EVENT_FLAGS_OFS = 12'hEC6;
  localparam logic [ADDR_W-1:0] ANALOG_EVENT_FLAGS_OFS = 12'hEC7;
  localparam logic [ADDR_W-1:0] SERIAL_EVENT_FLAGS_OFS = 12'hEC8;
  localparam logic [ADDR_W-1:0] TIMER_MATCH_OVERFLOW_FLAGS_OFS = 12'hEC9;
  localparam logic [ADDR_W-1:0] FLAG_OFS [FLAG_REGS] = '{TIMER_PIN_EVENT_FLAGS_OFS,
    CLOCK_CONVERTER_EVENT_FLAGS_OFS, ANALOG_EVENT_FLAGS_OFS, SERIAL_EVENT_FLAGS_OFS,
    TIMER_MATCH_OVERFLOW_FLAGS_OFS};

  // Control registers: external pin select per input, and edge polarity
  localparam logic [ADDR_W-1:0] EXT_IRQ_PIN_SELECT_OFS [EXT_COUNT] = '{12'hED0, 12'hED1, 12'hED2};
  localparam logic [ADDR_W-1:0] EXT_EDGE_SELECT_OFS = 12'hED3;

  // Register indices
  localparam int TPE = 0;
  localparam int CCE = 1;
  localparam int ANE = 2;
  localparam int SER = 3;
  localparam int TMO = 4;

  // Reset values
  localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [SEL_W-1:0] PIN_SELECT_RESET = 3'h0;
  localparam logic [EXT_COUNT-1:0] EDGE_SELECT_RESET = 3'h7;

  // Implemented and hardware-owned bit masks per register
  localparam logic [DATA_W-1:0] IMPL_MASK [FLAG_REGS] = '{8'h37, 8'hC3, 8'hC3, 8'hFF, 8'h3F};
  localparam logic [DATA_W-1:0] RO_MASK [FLAG_REGS] = '{8'h10, 8'h00, 8'h00, 8'hF0, 8'h00};

  // Bit positions
  localparam int EXT_PIN_BIT0 = 0;
  localparam int PIN_CHANGE_BIT = 4;
  localparam int TIMER_A_BIT = 5;
  localparam int CONV_DONE_BIT = 0;
  localparam int CONV_THRESH_BIT = 1;
  localparam int CLK_SWITCH_BIT = 6;
  localparam int OSC_FAIL_BIT = 7;
  localparam int COMPARATOR_BIT0 = 0;
  localparam int ZERO_CROSS_BIT = 6;
  localparam int VOLT_DETECT_BIT = 7;
  localparam int SYNC_DONE_BIT0 = 0;
  localparam int BUS_COLL_BIT0 = 1;
  localparam int TX_EMPTY_BIT0 = 4;
  localparam int RX_FULL_BIT0 = 5;
  localparam int PORT_STRIDE = 2;
  localparam int WIDE_OVF_BIT0 = 0;
  localparam int PERIOD_MATCH_BIT0 = 1;

  // One-cycle event pulses from the peripherals
  typedef struct packed {
    logic timerAOverflow;
    logic pinChangeEvent;
    logic oscFail;
    logic clockSwitchReady;
    logic conversionDone;
    logic converterThreshold;
    logic voltageDetect;
    logic zeroCross;
    logic [1:0] comparatorChange;
    logic [1:0] syncPortDone;
    logic [1:0] busCollision;
    logic [2:0] periodMatch;
    logic [2:0] wideOverflow;
  } pifb_event_type;

  // Levels that read-only flags follow
  typedef struct packed {
    logic [7:0] pinChangeFlagReg;
    logic [1:0] rxFull;
    logic [1:0] txEmpty;
  } pifb_level_type;

  // Register port request
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } pifb_bus_type;

endpackage : pifb_pkg

// [src/pifb_flag_bank.sv]
// Peripheral interrupt flag bank: five 8-bit flag registers plus external pin selection.
// Assumes peripheral events are one-cycle pulses on core_clk and all inputs are synchronous.

// How it works
// (RQ1) Timer A overflow sets flag bit 5 of register 0, held until cleared.
// (RQ2) Pin-change flag is read-only; set by event, cleared when pin-change flags clear.
// (RQ3) Three external pin flags in bits 0..2, set on their interrupt edge.
// (RQ4) Register 0 flags raise the request without the peripheral gate.
// (RQ5) Each external flag's pin comes from a pin-select register.
// (RQ6) Oscillator fail selects the internal fast oscillator and sets bit 7.
// (RQ7) Clock-switch ready sets bit 6; software clears it.
// (RQ8) Clock-switch flag alone never raises the wake request.
// (RQ9) Converter threshold sets bit 1 of register 1, held until cleared.
// (RQ10) Conversion done sets bit 0 of register 1, held until cleared.
// (RQ11) Voltage detect event sets bit 7 of register 2.
// (RQ12) Zero-cross change sets bit 6 of register 2, held until cleared.
// (RQ13) Comparator changes set bits 0 and 1 of register 2.
// (RQ14) Receive flags bits 5 and 7 are read-only, follow buffer-full levels.
// (RQ15) Transmit flags bits 4 and 6 are read-only, follow buffer-empty levels.
// (RQ16) Bus collision sets bit 1 or 3; software clears it.
// (RQ17) Sync port completion sets bit 0 or 2; software clears it.
// (RQ18) Period matches of three short timers set bits 1, 3, 5 of register 4.
// (RQ19) Overflows of three wide timers set bits 0, 2, 4 of register 4.
// (RQ20) Flags set regardless of any enable bit.
// (RQ21) Writing zero clears a flag; a same-cycle hardware set wins.
// (RQ22) Unimplemented bits read zero and ignore writes.
module pifb_flag_bank
  import pifb_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire pifb_bus_type busReq, // Register port request
  output logic [DATA_W-1:0] rdData, // Read data, cycle after read strobe
  input wire pifb_event_type events, // Peripheral event pulses
  input wire pifb_level_type levels, // Source levels for read-only flags
  input wire logic [PIN_COUNT-1:0] extPins, // Candidate external interrupt pins
  input wire logic peripheralIrqGate, // Peripheral interrupt gate level
  output logic irqRequest, // Interrupt request to the core
  output logic wakeRequest, // Wake request to the sleep controller
  output logic fastOscSelect // Clock input switched to internal fast oscillator
);

  logic [DATA_W-1:0] flagReg [FLAG_REGS];
  logic [DATA_W-1:0] setVec [FLAG_REGS];
  logic [DATA_W-1:0] roVal [FLAG_REGS];
  logic [FLAG_REGS-1:0] flagSel;
  logic [SEL_W-1:0] pinSelReg [EXT_COUNT];
  logic [EXT_COUNT-1:0] edgeSelReg;
  logic [EXT_COUNT-1:0] pinLevel;
  logic [EXT_COUNT-1:0] pinPrevReg;
  logic [EXT_COUNT-1:0] extEdge;
  logic [EXT_COUNT-1:0] pinSelHit;
  logic edgeSelHit;
  logic [DATA_W-1:0] rdData_next;
  logic [DATA_W-1:0] rdData_reg;
  logic irqRequest_reg;
  logic wakeRequest_reg;
  logic fastOscSelect_reg;
  logic peripheralAny;
  logic wakeAny;
  logic [DATA_W-1:0] wakeMask;

  // One clock and reset for every check below
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Address decode
  always_comb begin
    for (int r = 0; r < FLAG_REGS; r++) begin
      flagSel[r] = (busReq.addr == FLAG_OFS[r]);
    end
    for (int e = 0; e < EXT_COUNT; e++) begin
      pinSelHit[e] = (busReq.addr == EXT_IRQ_PIN_SELECT_OFS[e]);
    end
    edgeSelHit = (busReq.addr == EXT_EDGE_SELECT_OFS);
  end

  // Pin select and edge polarity control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int e = 0; e < EXT_COUNT; e++) begin
        pinSelReg[e] <= PIN_SELECT_RESET;
      end
      edgeSelReg <= EDGE_SELECT_RESET;
    end else if (busReq.wrStrobe) begin
      for (int e = 0; e < EXT_COUNT; e++) begin
        if (pinSelHit[e]) begin
          pinSelReg[e] <= busReq.wrData[SEL_W-1:0];
        end
      end
      if (edgeSelHit) begin
        edgeSelReg <= busReq.wrData[EXT_COUNT-1:0];
      end
    end
  end

  // External pin routing and edge detection
  generate
    for (genvar e = 0; e < EXT_COUNT; e++) begin : g_ext
      // (RQ5) pin chosen by select
      assign pinLevel[e] = extPins[pinSelReg[e]];
      // (RQ3) rising or falling edge
      assign extEdge[e] = edgeSelReg[e] ? (pinLevel[e] & ~pinPrevReg[e]) : (~pinLevel[e] & pinPrevReg[e]);
    end
  endgenerate

  // Previous level of each selected pin; follows the pin in reset too,
  // so a pin that idles high shows no false edge at release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinPrevReg <= pinLevel;
    end else begin
      pinPrevReg <= pinLevel;
    end
  end

  // Hardware set vectors, never gated by enables
  always_comb begin
    for (int r = 0; r < FLAG_REGS; r++) begin
      setVec[r] = '0;
      roVal[r] = '0;
    end
    // (RQ20) no enable gating
    // (RQ1) timer A overflow
    setVec[TPE][TIMER_A_BIT] = events.timerAOverflow;
    // (RQ3) external pin flags
    setVec[TPE][EXT_PIN_BIT0 +: EXT_COUNT] = extEdge;
    // (RQ2) pin change set and release
    roVal[TPE][PIN_CHANGE_BIT] = events.pinChangeEvent
      | (flagReg[TPE][PIN_CHANGE_BIT] & (|levels.pinChangeFlagReg));
    // (RQ6) oscillator fail flag
    setVec[CCE][OSC_FAIL_BIT] = events.oscFail;
    // (RQ7) clock switch ready
    setVec[CCE][CLK_SWITCH_BIT] = events.clockSwitchReady;
    // (RQ9) converter threshold
    setVec[CCE][CONV_THRESH_BIT] = events.converterThreshold;
    // (RQ10) conversion done
    setVec[CCE][CONV_DONE_BIT] = events.conversionDone;
    // (RQ11) voltage detect
    setVec[ANE][VOLT_DETECT_BIT] = events.voltageDetect;
    // (RQ12) zero cross
    setVec[ANE][ZERO_CROSS_BIT] = events.zeroCross;
    // (RQ13) comparator changes
    setVec[ANE][COMPARATOR_BIT0 +: 2] = events.comparatorChange;
    for (int p = 0; p < 2; p++) begin
      // (RQ17) sync port completion
      setVec[SER][SYNC_DONE_BIT0 + PORT_STRIDE * p] = events.syncPortDone[p];
      // (RQ16) bus collision
      setVec[SER][BUS_COLL_BIT0 + PORT_STRIDE * p] = events.busCollision[p];
      // (RQ15) transmit buffer empty
      roVal[SER][TX_EMPTY_BIT0 + PORT_STRIDE * p] = levels.txEmpty[p];
      // (RQ14) receive buffer full
      roVal[SER][RX_FULL_BIT0 + PORT_STRIDE * p] = levels.rxFull[p];
    end
    for (int t = 0; t < 3; t++) begin
      // (RQ19) wide timer overflow
      setVec[TMO][WIDE_OVF_BIT0 + PORT_STRIDE * t] = events.wideOverflow[t];
      // (RQ18) period match
      setVec[TMO][PERIOD_MATCH_BIT0 + PORT_STRIDE * t] = events.periodMatch[t];
    end
  end

  // Flag registers
  generate
    for (genvar r = 0; r < FLAG_REGS; r++) begin : g_flag
      logic [DATA_W-1:0] swVal;
      logic [DATA_W-1:0] flag_next;
      // (RQ21) write value, then hardware set wins
      assign swVal = (busReq.wrStrobe && flagSel[r]) ? busReq.wrData : flagReg[r];
      // (RQ22) unimplemented bits forced to zero
      assign flag_next = (((swVal | setVec[r]) & ~RO_MASK[r]) | (roVal[r] & RO_MASK[r])) & IMPL_MASK[r];
      always_ff @(posedge core_clk) begin
        if (rst) begin
          flagReg[r] <= FLAG_RESET;
        end else begin
          flagReg[r] <= flag_next;
        end
      end

      // (RQ22)
      unimpl_zero_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ22)
        (flagReg[r] & ~IMPL_MASK[r]) == '0)
        else $error("unimplemented flag bit set");
      // (RQ21)
      write_zero_clear_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ21)
        (busReq.wrStrobe && flagSel[r] && setVec[r] == '0)
        |=> ((flagReg[r] & ~RO_MASK[r]) == ($past(busReq.wrData) & IMPL_MASK[r] & ~RO_MASK[r])))
        else $error("flag write did not take the written value");
      // (RQ21) drop only on write
      flag_hold_a: assert property ( // (RQ21)
        !(busReq.wrStrobe && flagSel[r]) |=> (($past(flagReg[r]) & ~flagReg[r] & ~RO_MASK[r]) == '0))
        else $error("flag dropped without a write");
    end
  endgenerate

  // Read data, valid only in the cycle after the strobe
  always_comb begin
    rdData_next = '0;
    for (int r = 0; r < FLAG_REGS; r++) begin
      if (flagSel[r]) begin
        rdData_next = flagReg[r];
      end
    end
    for (int e = 0; e < EXT_COUNT; e++) begin
      if (pinSelHit[e]) begin
        rdData_next = {{(DATA_W-SEL_W){1'b0}}, pinSelReg[e]};
      end
    end
    if (edgeSelHit) begin
      rdData_next = {{(DATA_W-EXT_COUNT){1'b0}}, edgeSelReg};
    end
  end

  // Read data register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_reg <= '0;
    end else if (busReq.rdStrobe) begin
      rdData_reg <= rdData_next;
    end else begin
      rdData_reg <= '0;
    end
  end

  // Request summaries
  always_comb begin
    peripheralAny = 1'b0;
    wakeAny = |flagReg[TPE];
    for (int r = 1; r < FLAG_REGS; r++) begin
      peripheralAny = peripheralAny | (|flagReg[r]);
      wakeMask = (r == CCE) ? ~(DATA_W'(1) << CLK_SWITCH_BIT) : '1;
      // (RQ8) clock-switch flag excluded from wake
      wakeAny = wakeAny | (|(flagReg[r] & wakeMask));
    end
    if (FLAG_REGS < 2) begin
      wakeMask = '1;
    end
  end

  // Interrupt and wake requests
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqRequest_reg <= 1'b0;
      wakeRequest_reg <= 1'b0;
    end else begin
      // (RQ4) register 0 ignores the peripheral gate
      irqRequest_reg <= (|flagReg[TPE]) | (peripheralIrqGate & peripheralAny);
      wakeRequest_reg <= wakeAny;
    end
  end

  // Clock source switch on oscillator failure
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fastOscSelect_reg <= 1'b0;
    end else if (events.oscFail) begin
      // (RQ6) fall back to internal fast oscillator
      fastOscSelect_reg <= 1'b1;
    end
  end

  assign rdData = rdData_reg;
  assign irqRequest = irqRequest_reg;
  assign wakeRequest = wakeRequest_reg;
  assign fastOscSelect = fastOscSelect_reg;

  // Checks
  // (RQ1)
  timer_a_set_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ1)
    events.timerAOverflow |=> flagReg[TPE][TIMER_A_BIT])
    else $error("timer A overflow flag not set");
  // (RQ2)
  pin_change_release_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ2)
    (levels.pinChangeFlagReg == '0 && !events.pinChangeEvent) |=> !flagReg[TPE][PIN_CHANGE_BIT])
    else $error("pin change flag not released");
  pin_change_hold_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ2)
    (flagReg[TPE][PIN_CHANGE_BIT] && levels.pinChangeFlagReg != '0) |=> flagReg[TPE][PIN_CHANGE_BIT])
    else $error("pin change flag dropped early");
  // (RQ3)
  ext_edge_flag_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ3)
    (extEdge != '0) |=> ((flagReg[TPE][EXT_PIN_BIT0 +: EXT_COUNT] & $past(extEdge)) == $past(extEdge)))
    else $error("external pin flag missed its edge");
  // (RQ5)
  pin_select_route_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ5)
    (edgeSelReg[0] && !pinPrevReg[0] && extPins[pinSelReg[0]]) |=> flagReg[TPE][EXT_PIN_BIT0])
    else $error("selected pin edge not flagged");
  // (RQ4)
  fixed_group_irq_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ4)
    (|flagReg[TPE]) |=> irqRequest)
    else $error("register 0 flag did not raise request");
  // (RQ6)
  osc_fail_switch_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ6)
    events.oscFail |=> (fastOscSelect && flagReg[CCE][OSC_FAIL_BIT]))
    else $error("oscillator fail not handled");
  // (RQ8)
  switch_no_wake_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ8)
    (flagReg[CCE] == (DATA_W'(1) << CLK_SWITCH_BIT) && flagReg[TPE] == '0 && flagReg[ANE] == '0
      && flagReg[SER] == '0 && flagReg[TMO] == '0) |=> !wakeRequest)
    else $error("clock switch flag woke the system");
  // (RQ21)
  set_beats_clear_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ21)
    (events.wideOverflow[0] && busReq.wrStrobe && flagSel[TMO]) |=> flagReg[TMO][WIDE_OVF_BIT0])
    else $error("timer overflow set lost to a clear");
  // (RQ14)
  serial_follow_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ14)
    1'b1 |=> (flagReg[SER][RX_FULL_BIT0] == $past(levels.rxFull[0])
      && flagReg[SER][TX_EMPTY_BIT0 + PORT_STRIDE] == $past(levels.txEmpty[1])))
    else $error("serial flag does not follow its buffer");
  // (RQ18)
  period_match_a: assert property (@(posedge core_clk) disable iff (rst) // (RQ18)
    events.periodMatch[2] |=> flagReg[TMO][PERIOD_MATCH_BIT0 + 2 * PORT_STRIDE])
    else $error("period match flag not set");
  // (RQ2) pin change set
  pin_change_set_a: assert property ( // (RQ2)
    events.pinChangeEvent |=> flagReg[TPE][PIN_CHANGE_BIT])
    else $error("pin change flag not set");
  // (RQ7) clock switch set
  clock_switch_set_a: assert property ( // (RQ7)
    events.clockSwitchReady |=> flagReg[CCE][CLK_SWITCH_BIT])
    else $error("clock switch flag not set");
  // (RQ9) threshold flag set
  conv_thresh_set_a: assert property ( // (RQ9)
    events.converterThreshold |=> flagReg[CCE][CONV_THRESH_BIT])
    else $error("threshold flag not set");
  // (RQ10) conversion flag set
  conv_done_set_a: assert property ( // (RQ10)
    events.conversionDone |=> flagReg[CCE][CONV_DONE_BIT])
    else $error("conversion flag not set");
  // (RQ11) voltage flag set
  volt_detect_set_a: assert property ( // (RQ11)
    events.voltageDetect |=> flagReg[ANE][VOLT_DETECT_BIT])
    else $error("voltage detect flag not set");
  // (RQ12) zero cross set
  zero_cross_set_a: assert property ( // (RQ12)
    events.zeroCross |=> flagReg[ANE][ZERO_CROSS_BIT])
    else $error("zero cross flag not set");
  // (RQ13) comparator flags set
  comparator_set_a: assert property ( // (RQ13)
    (events.comparatorChange != '0) |=> ((flagReg[ANE][COMPARATOR_BIT0 +: 2]
      & $past(events.comparatorChange)) == $past(events.comparatorChange)))
    else $error("comparator flag not set");
  // (RQ14) second receive copy
  rx_follow_a: assert property ( // (RQ14)
    1'b1 |=> (flagReg[SER][RX_FULL_BIT0 + PORT_STRIDE] == $past(levels.rxFull[1])))
    else $error("receive flag does not follow its buffer");
  // (RQ15) first transmit copy
  tx_follow_a: assert property ( // (RQ15)
    1'b1 |=> (flagReg[SER][TX_EMPTY_BIT0] == $past(levels.txEmpty[0])))
    else $error("transmit flag does not follow its buffer");
  // (RQ16) collision flag set
  bus_collision_set_a: assert property ( // (RQ16)
    events.busCollision[1] |=> flagReg[SER][BUS_COLL_BIT0 + PORT_STRIDE])
    else $error("bus collision flag not set");
  // (RQ17) completion flag set
  sync_done_set_a: assert property ( // (RQ17)
    events.syncPortDone[0] |=> flagReg[SER][SYNC_DONE_BIT0])
    else $error("sync port flag not set");
  // (RQ19) overflow flag set
  wide_overflow_set_a: assert property ( // (RQ19)
    events.wideOverflow[1] |=> flagReg[TMO][WIDE_OVF_BIT0 + PORT_STRIDE])
    else $error("wide timer overflow flag not set");
  // (RQ4) gate masks peripherals
  gate_masks_irq_a: assert property ( // (RQ4)
    (!peripheralIrqGate && flagReg[TPE] == '0) |=> !irqRequest)
    else $error("gated peripheral flag raised request");
  // (RQ6) fallback stays selected
  osc_select_sticky_a: assert property ( // (RQ6)
    fastOscSelect |=> fastOscSelect)
    else $error("oscillator fallback dropped");
  read_timing_a: assert property (@(posedge core_clk) disable iff (rst)
    !busReq.rdStrobe |=> rdData == '0)
    else $error("read data outside the answer cycle");

  // Scenarios
  cover_ext_edge_c: cover property (@(posedge core_clk) disable iff (rst) extEdge != '0);
  cover_clear_c: cover property (@(posedge core_clk) disable iff (rst)
    busReq.wrStrobe && flagSel[CCE] && flagReg[CCE] != '0);
  cover_osc_fail_c: cover property (@(posedge core_clk) disable iff (rst) events.oscFail);
  cover_pin_release_c: cover property (@(posedge core_clk) disable iff (rst)
    $fell(flagReg[TPE][PIN_CHANGE_BIT]));
  cover_wake_only_c: cover property (wakeRequest && !irqRequest);

endmodule : pifb_flag_bank

// [testbench/pifb_periph_model.sv]
// Peripheral model: raises event pulses, buffer levels and external pin levels.
// Assumes the bench calls its tasks from one process; all changes land on a clock edge.
module pifb_periph_model
  import pifb_pkg::*;
(
  input wire logic core_clk, // System clock
  output pifb_event_type events, // One-cycle event pulses
  output pifb_level_type levels, // Source levels for read-only flags
  output logic [PIN_COUNT-1:0] extPins // Candidate external pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet sources at time zero
  initial begin
    events = '0;
    levels = '0;
    extPins = '0;
  end

  // Events are single-cycle pulses, never held longer
  task automatic pulse(input pifb_event_type ev);
    @(posedge core_clk);
    events <= ev;
    @(posedge core_clk);
    events <= '0;
  endtask : pulse

  // Levels change right after an edge and then hold
  task automatic setLevels(input pifb_level_type lv);
    @(posedge core_clk);
    levels <= lv;
  endtask : setLevels

  // One pin moves after an edge
  task automatic setPin(input int p, input logic v);
    @(posedge core_clk);
    extPins[p] <= v;
  endtask : setPin
endmodule : pifb_periph_model

// [testbench/test_peripheral_irq_flag_bank.sv]
// Bench for the flag bank: register port driver, reference model of all flags, closing verdict.
// Assumes the peripheral model drives events, levels and pins on the same clock.
module test_peripheral_irq_flag_bank
  import pifb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHECK_EQ(what, expv, gotv) begin testsRun++; if ((gotv) !== (expv)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", what, expv, gotv); end end

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  pifb_bus_type busReq = '0;
  logic [DATA_W-1:0] rdData;
  pifb_event_type events;
  pifb_level_type levels;
  logic [PIN_COUNT-1:0] extPins;
  logic peripheralIrqGate = 1'b0;
  logic irqRequest, wakeRequest, fastOscSelect;
  int mismatches = 0;
  int testsRun = 0;
  int cycles = 0;
  int seed = 32'hCD6C1231;
  int expFlags [FLAG_REGS];
  int pinSel [EXT_COUNT];
  logic edgeSel [EXT_COUNT];
  // Flag position reg*8+bit for each event bit, lowest struct bit first
  int loc [20] = '{32, 34, 36, 33, 35, 37, 25, 27, 24, 26, 16, 17, 22, 23, 9, 8, 14, 15, 4, 5};
  logic [$bits(pifb_event_type)-1:0] evBits;
  logic [DATA_W-1:0] d;
  int r;

  always #2.5 core_clk = ~core_clk;

  pifb_flag_bank u_dut (.core_clk(core_clk), .rst(rst), .busReq(busReq), .rdData(rdData), .events(events),
    .levels(levels), .extPins(extPins), .peripheralIrqGate(peripheralIrqGate), .irqRequest(irqRequest),
    .wakeRequest(wakeRequest), .fastOscSelect(fastOscSelect));

  pifb_periph_model u_periph (.core_clk(core_clk), .events(events), .levels(levels), .extPins(extPins));

  // Verdict and end of run
  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrapUp

  // Hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrapUp();
    end
  end

  // One-cycle write strobe
  task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk);
    busReq <= '{wrStrobe: 1'b1, rdStrobe: 1'b0, addr: a, wrData: v};
    @(posedge core_clk);
    busReq.wrStrobe <= 1'b0;
  endtask : busWrite

  // One-cycle read strobe, data taken in the following cycle
  task automatic busRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge core_clk);
    busReq <= '{wrStrobe: 1'b0, rdStrobe: 1'b1, addr: a, wrData: 8'h00};
    @(posedge core_clk);
    busReq.rdStrobe <= 1'b0;
    #1;
    v = rdData;
  endtask : busRead

  // Software write: only writable implemented bits take the value
  task automatic swWrite(input int n, input logic [DATA_W-1:0] v);
    busWrite(FLAG_OFS[n], v);
    expFlags[n] = (v & IMPL_MASK[n] & ~RO_MASK[n]) | (expFlags[n] & RO_MASK[n]);
  endtask : swWrite

  task automatic checkReg(input int n);
    logic [DATA_W-1:0] v;
    busRead(FLAG_OFS[n], v);
    `CHECK_EQ("flag register", 8'(expFlags[n]), v)
  endtask : checkReg

  // Request outputs from the model's flags and the gate
  task automatic checkOuts();
    int others;
    logic expIrq;
    logic expWake;
    others = expFlags[1] | expFlags[2] | expFlags[3] | expFlags[4];
    expIrq = (expFlags[0] != 0) || (peripheralIrqGate && others != 0);
    expWake = (expFlags[0] | expFlags[2] | expFlags[3] | expFlags[4] | (expFlags[1] & 32'hBF)) != 0;
    `CHECK_EQ("irq request", expIrq, irqRequest)
    `CHECK_EQ("wake request", expWake, wakeRequest)
  endtask : checkOuts

  // Pin move and its expected external flags
  task automatic pinTo(input int p, input logic v);
    u_periph.setPin(p, v);
    for (int j = 0; j < EXT_COUNT; j++) begin
      if (pinSel[j] == p && edgeSel[j] == v) begin
        expFlags[0] |= 1 << j;
      end
    end
    repeat (2) @(posedge core_clk);
  endtask : pinTo

  task automatic checkResetState();
    logic [DATA_W-1:0] v;
    for (int n = 0; n < FLAG_REGS; n++) begin
      expFlags[n] = 0;
      checkReg(n);
    end
    for (int j = 0; j < EXT_COUNT; j++) begin
      pinSel[j] = 0;
      edgeSel[j] = 1'b1;
    end
    busRead(EXT_EDGE_SELECT_OFS, v);
    `CHECK_EQ("edge select", EDGE_SELECT_RESET, v[2:0])
    `CHECK_EQ("oscillator select", 1'b0, fastOscSelect)
  endtask : checkResetState

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    checkResetState();
    // Unmapped place reads zero; read data lasts one cycle
    busWrite(12'hECA, 8'hFF);
    busRead(12'hECA, d);
    `CHECK_EQ("unmapped read", 8'h00, d)
    @(posedge core_clk);
    #1;
    `CHECK_EQ("idle read data", 8'h00, rdData)
    // Each event except pin change sets its own flag, polled with no enable, then cleared
    for (int k = 0; k < 20; k++) begin
      if (k != 18) begin
        r = loc[k] / 8;
        @(posedge core_clk);
        peripheralIrqGate <= 1'($random(seed));
        evBits = '0;
        evBits[k] = 1'b1;
        u_periph.pulse(pifb_event_type'(evBits));
        expFlags[r] |= 1 << (loc[k] % 8);
        checkReg(r);
        checkOuts();
        swWrite(r, 8'h00);
        checkReg(r);
      end
    end
    `CHECK_EQ("oscillator select", 1'b1, fastOscSelect)
    // Hardware set beats a clear in the same cycle
    fork
      u_periph.pulse(pifb_event_type'(20'h00001));
      swWrite(TMO, 8'h00);
    join
    expFlags[TMO] |= 1;
    checkReg(TMO);
    // Pin-change flag follows its source register, not software
    u_periph.setLevels('{pinChangeFlagReg: 8'h04, rxFull: 2'b00, txEmpty: 2'b00});
    u_periph.pulse(pifb_event_type'(20'h40000));
    expFlags[TPE] |= 8'h10;
    swWrite(TPE, 8'h00);
    checkReg(TPE);
    u_periph.setLevels('0);
    expFlags[TPE] &= 8'hEF;
    repeat (2) @(posedge core_clk);
    checkReg(TPE);
    // Serial buffer flags are copies of buffer levels and ignore writes
    for (int n = 1; n < 16; n += 5) begin
      u_periph.setLevels('{pinChangeFlagReg: 8'h00, rxFull: n[1:0], txEmpty: n[3:2]});
      expFlags[SER] = (expFlags[SER] & 8'h0F) | {n[1], n[3], n[0], n[2], 4'h0};
      swWrite(SER, 8'h00);
      checkReg(SER);
    end
    u_periph.setLevels('0);
    expFlags[SER] &= 8'h0F;
    // External flags follow the selected pin and edge
    for (int i = 0; i < EXT_COUNT; i++) begin
      pinSel[i] = $random(seed) & 7;
      busWrite(EXT_IRQ_PIN_SELECT_OFS[i], 8'(pinSel[i]));
      busRead(EXT_IRQ_PIN_SELECT_OFS[i], d);
      `CHECK_EQ("pin select", 8'(pinSel[i]), d)
      for (int e = 1; e >= 0; e--) begin
        edgeSel[i] = e[0];
        busWrite(EXT_EDGE_SELECT_OFS, 8'((7 & ~(1 << i)) | (e << i)));
        pinTo(pinSel[i], 1'b1);
        pinTo(pinSel[i], 1'b0);
        checkReg(TPE);
        swWrite(TPE, 8'h00);
      end
      edgeSel[i] = 1'b1;
      busWrite(EXT_EDGE_SELECT_OFS, 8'h07);
    end
    // Random writes land only on writable, implemented bits
    for (int n = 0; n < 12; n++) begin
      r = ($random(seed) & 32'h7FFFFFFF) % FLAG_REGS;
      @(posedge core_clk);
      peripheralIrqGate <= 1'($random(seed));
      swWrite(r, 8'($random(seed)));
      checkReg(r);
      checkOuts();
    end
    // Second reset in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    checkResetState();
    wrapUp();
  end
endmodule : test_peripheral_irq_flag_bank
